// ===== logic/mcg_pkg.sv
package mcg_pkg;

	// Register byte offsets on the AHB-Lite slave
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_ADDRSW = 8'h08;
	localparam logic [7:0] ADDR_BUSREQ = 8'h0C;
	localparam logic [7:0] ADDR_XCVR   = 8'h10;
	localparam logic [7:0] ADDR_TIMER  = 8'h14;
	localparam logic [7:0] ADDR_DECODE = 8'h18;

	// Control latch fields
	localparam int CTRL_GAIN  = 0;
	localparam int CTRL_YTF   = 1;
	localparam int CTRL_ACT   = 2;
	localparam int CTRL_ERR   = 3;
	localparam int CTRL_FLASH = 4;
	localparam int CTRL_OSC   = 5;
	localparam int CTRL_RUN   = 6;
	localparam int CTRL_W     = 7;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h60;

	// Status fields
	localparam int ST_IFREF  = 0;
	localparam int ST_REF300 = 1;
	localparam int ST_NVPROT = 2;
	localparam int ST_VCOLK  = 3;
	localparam int ST_NVWARN = 4;
	localparam int ST_GRANT  = 5;
	localparam int ST_REQ    = 6;
	localparam int ST_TIMIRQ = 7;
	localparam int ST_BUSIRQ = 8;
	localparam int ST_LCLK   = 9;

	// Transceiver direction field
	localparam logic [1:0] XCVR_IDLE = 2'h0;
	localparam logic [1:0] XCVR_RX   = 2'h1;
	localparam logic [1:0] XCVR_TX   = 2'h2;

	// Interrupt level codes, true sense
	localparam logic [2:0] LVL_NONE  = 3'h0;
	localparam logic [2:0] LVL_BUS   = 3'h5;
	localparam logic [2:0] LVL_TIMER = 3'h6;

	localparam int XCVR_W  = 9;
	localparam int ADDR_SW_W = 8;

	// Oscillator rate and processor division
	localparam int OSC_DIV = 2;

	// Flash half period of the error indicator
	localparam int CLK_HZ        = 20_000_000;
	localparam int FLASH_HALF_MS = 250;
	localparam int FLASH_CYCLES  = CLK_HZ / 1000 * FLASH_HALF_MS;

	typedef enum logic [1:0] {
		ACK_IDLE = 2'b00,
		ACK_WAIT = 2'b01,
		ACK_DONE = 2'b10
	} mcg_ack_e;

endpackage : mcg_pkg

// ===== logic/mcg_glue.sv
`timescale 1ns/1ps
module mcg_glue
	import mcg_pkg::*;
#(
	parameter int FLASH_CNT = mcg_pkg::FLASH_CYCLES
) (
	input  wire logic                          hclk,
	input  wire logic                          hresetn,
	input  wire logic                          hsel,
	input  wire logic [31:0]                   haddr,
	input  wire logic [1:0]                    htrans,
	input  wire logic                          hwrite,
	input  wire logic [2:0]                    hsize,
	input  wire logic [31:0]                   hwdata,
	input  wire logic                          hready,
	output logic      [31:0]                   hrdata,
	output logic                               hreadyout,
	output logic                               hresp,
	output logic                               cpu_clk_en,
	output logic                               proc_reset_n,
	output logic                               proc_stop_n,
	input  wire logic                          cpu_as_n,
	output logic                               bus_cycle_ack_n,
	output logic      [2:0]                    ipl_n,
	input  wire logic                          timer_irq,
	input  wire logic                          bus_irq,
	input  wire logic [mcg_pkg::ADDR_SW_W-1:0] addr_sw,
	output logic                               rx_dir_n,
	output logic                               rx_en_n,
	output logic                               tx_dir_n,
	output logic                               tx_en_n,
	output logic                               rts_n,
	input  wire logic                          cts_n,
	input  wire logic                          module_bus_clock,
	input  wire logic                          bus_reset_n,
	output logic                               gain_en,
	output logic                               ytf_en,
	output logic                               act_led,
	output logic                               err_led,
	input  wire logic [3:0]                    det_in,
	input  wire logic                          nv_wp_sw,
	output logic                               nv_we_allow,
	output logic      [3:0]                    mem_sel
);
	import mcg_pkg::*;

	typedef struct packed {
		logic [1:0]           ifr1, ifr2;
		logic [3:0]           det1, det2;
		logic                 wp1, wp2;
		logic                 cts1, cts2;
		logic                 lck1, lck2, lck3;
		logic                 brst1, brst2;
		logic                 as1, as2;
		logic [ADDR_SW_W-1:0] sw1, sw2;
		logic                 div;
		logic                 osc_en;
		logic [CTRL_W-1:0]    ctrl;
		logic                 req;
		logic [1:0]           xcvr;
		logic [3:0]           dec;
		logic [31:0]          flash_cnt;
		logic                 flash;
		mcg_ack_e             ack;
		logic                 ack_n;
		logic [2:0]           ipl_n;
		logic                 ph_val;
		logic                 ph_wr;
		logic [7:0]           ph_addr;
		logic [31:0]          rdata;
	} mcg_state_s;

	mcg_state_s s_q, s_d;
	logic       irq_any;
	logic [2:0] lvl;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d = s_q;
		// Two-flop synchronisers, three flops for the bus clock; stage one read only by stage two
		s_d.ifr1  = {timer_irq, bus_irq};
		s_d.ifr2  = s_q.ifr1;
		s_d.det1  = det_in;
		s_d.det2  = s_q.det1;
		s_d.wp1   = nv_wp_sw;
		s_d.wp2   = s_q.wp1;
		s_d.cts1  = cts_n;
		s_d.cts2  = s_q.cts1;
		s_d.lck1  = module_bus_clock;
		s_d.lck2  = s_q.lck1;
		s_d.lck3  = s_q.lck2;
		s_d.brst1 = bus_reset_n;
		s_d.brst2 = s_q.brst1;
		s_d.as1   = cpu_as_n;
		s_d.as2   = s_q.as1;
		s_d.sw1   = addr_sw;
		s_d.sw2   = s_q.sw1;

		// Clock division and enable
		s_d.osc_en = s_q.ctrl[CTRL_OSC];
		s_d.div    = s_q.osc_en ? ~s_q.div : 1'b0;

		// Interrupt priority: timer above bus
		lvl = s_q.ifr2[1] ? LVL_TIMER : (s_q.ifr2[0] ? LVL_BUS : LVL_NONE);
		s_d.ipl_n = ~lvl;
		irq_any = (s_q.ipl_n != ~LVL_NONE);

		// Acknowledge machine
		unique case (s_q.ack)
			ACK_IDLE: begin
				s_d.ack_n = 1'b1;
				if (!s_q.as2 && !irq_any)
					s_d.ack = ACK_WAIT;
			end
			ACK_WAIT: begin
				if (irq_any) begin
					s_d.ack_n = 1'b1;
					s_d.ack   = ACK_IDLE;
				end else begin
					s_d.ack_n = 1'b0;
					s_d.ack   = ACK_DONE;
				end
			end
			ACK_DONE: begin
				if (s_q.as2) begin
					s_d.ack_n = 1'b1;
					s_d.ack   = ACK_IDLE;
				end
			end
			default: begin
				s_d.ack_n = 1'b1;
				s_d.ack   = ACK_IDLE;
			end
		endcase

		// Bus request held until grant; bus reset clears it
		if (!s_q.cts2)
			s_d.req = 1'b0;
		if (!s_q.brst2) begin
			s_d.req  = 1'b0;
			s_d.xcvr = XCVR_IDLE;
		end

		// Error indicator flashing after failed self-test
		if (s_q.ctrl[CTRL_FLASH]) begin
			if (s_q.flash_cnt >= FLASH_CNT - 1) begin
				s_d.flash_cnt = '0;
				s_d.flash     = ~s_q.flash;
			end else begin
				s_d.flash_cnt = s_q.flash_cnt + 32'h0000_0001;
			end
		end else begin
			s_d.flash_cnt = '0;
			s_d.flash     = 1'b0;
		end

		// AHB-Lite data phase write and read capture
		if (s_q.ph_val && s_q.ph_wr) begin
			unique case (s_q.ph_addr)
				ADDR_CTRL:   s_d.ctrl = hwdata[CTRL_W-1:0];
				ADDR_BUSREQ: if (hwdata[0] && s_q.brst2) s_d.req = 1'b1;
				ADDR_XCVR:   if (s_q.brst2) s_d.xcvr = hwdata[1:0];
				ADDR_DECODE: s_d.dec = hwdata[3:0];
				default: ;
			endcase
		end
		s_d.ph_val = hsel && hready && htrans[1];
		if (hsel && hready) begin
			s_d.ph_wr   = hwrite;
			s_d.ph_addr = haddr[7:0];
		end
		s_d.rdata = 32'h0000_0000;
		if (hsel && hready && htrans[1] && !hwrite) begin
			unique case (haddr[7:0])
				ADDR_CTRL:   s_d.rdata = {25'h0, s_q.ctrl};
				// Fields placed by the package positions, not by a hand-built concatenation
				ADDR_STATUS: begin
					s_d.rdata[ST_IFREF]  = s_q.det2[0];
					s_d.rdata[ST_REF300] = s_q.det2[1];
					s_d.rdata[ST_NVPROT] = s_q.wp2;
					s_d.rdata[ST_VCOLK]  = s_q.det2[3];
					s_d.rdata[ST_NVWARN] = ~s_q.wp2;
					s_d.rdata[ST_GRANT]  = ~s_q.cts2;
					s_d.rdata[ST_REQ]    = s_q.req;
					s_d.rdata[ST_TIMIRQ] = s_q.ifr2[1];
					s_d.rdata[ST_BUSIRQ] = s_q.ifr2[0];
					s_d.rdata[ST_LCLK]   = s_q.lck3;
				end
				ADDR_ADDRSW: s_d.rdata = {24'h0, s_q.sw2};
				ADDR_BUSREQ: s_d.rdata = {31'h0, s_q.req};
				ADDR_XCVR:   s_d.rdata = {30'h0, s_q.xcvr};
				ADDR_DECODE: s_d.rdata = {28'h0, s_q.dec};
				default:     s_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q       <= '0;
			s_q.ctrl  <= CTRL_RESET;
			s_q.cts1  <= 1'b1;
			s_q.cts2  <= 1'b1;
			s_q.brst1 <= 1'b1;
			s_q.brst2 <= 1'b1;
			s_q.as1   <= 1'b1;
			s_q.as2   <= 1'b1;
			s_q.ack   <= ACK_IDLE;
			s_q.ack_n <= 1'b1;
			s_q.ipl_n <= 3'h7;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign hrdata          = s_q.rdata;
	assign hreadyout       = 1'b1;
	assign hresp           = 1'b0;
	assign cpu_clk_en      = s_q.div;
	assign proc_reset_n    = s_q.ctrl[CTRL_RUN];
	assign proc_stop_n     = s_q.ctrl[CTRL_RUN];
	assign bus_cycle_ack_n = s_q.ack_n;
	assign ipl_n           = s_q.ipl_n;
	// Active-low pairs of transceiver controls
	assign rx_dir_n        = ~(s_q.xcvr == XCVR_RX);
	assign rx_en_n         = ~(s_q.xcvr == XCVR_RX);
	assign tx_dir_n        = ~(s_q.xcvr == XCVR_TX);
	assign tx_en_n         = ~(s_q.xcvr == XCVR_TX);
	assign rts_n           = ~s_q.req;
	assign gain_en         = s_q.ctrl[CTRL_GAIN];
	assign ytf_en          = s_q.ctrl[CTRL_YTF];
	assign act_led         = s_q.ctrl[CTRL_ACT];
	assign err_led         = s_q.ctrl[CTRL_ERR] | s_q.flash;
	// Switch low means write position
	assign nv_we_allow     = ~s_q.wp2;
	assign mem_sel         = s_q.dec;

	////////////////////////////////////////////////////////////////////////
	sequence acc_start;
		!s_q.as2 && s_q.ack == ACK_IDLE && !irq_any;
	endsequence

	chk_ack_given: assert property (@(posedge hclk) disable iff (!hresetn)
		acc_start ##1 !irq_any |-> ##1 !bus_cycle_ack_n)
		else $error("acknowledge missing");
	chk_ack_irq_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		irq_any |=> bus_cycle_ack_n)
		else $error("acknowledge during interrupt");
	chk_ack_release: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_q.ack == ACK_DONE && s_q.as2) |=> bus_cycle_ack_n)
		else $error("acknowledge not released");
	chk_clk_half: assert property (@(posedge hclk) disable iff (!hresetn)
		cpu_clk_en |=> !cpu_clk_en)
		else $error("clock enable too fast");
	chk_osc_stop: assert property (@(posedge hclk) disable iff (!hresetn)
		!s_q.osc_en |=> !cpu_clk_en)
		else $error("clock runs while disabled");
	chk_level_timer: assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.ifr2[1] |=> ipl_n == ~LVL_TIMER)
		else $error("timer level wrong");
	chk_level_bus: assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.ifr2 == 2'b01 |=> ipl_n == ~LVL_BUS)
		else $error("bus level wrong");
	chk_level_none: assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.ifr2 == 2'b00 |=> ipl_n == 3'h7)
		else $error("idle level wrong");
	chk_req_grant: assert property (@(posedge hclk) disable iff (!hresetn)
		!s_q.cts2 && !(s_q.ph_val && s_q.ph_wr) |=> rts_n)
		else $error("request not dropped on grant");
	chk_bus_reset: assert property (@(posedge hclk) disable iff (!hresetn)
		!s_q.brst2 |=> rts_n && rx_en_n && tx_en_n)
		else $error("bus reset ignored");

	// Only the three used level codes may ever reach the processor
	chk_ipl_code: assert property (@(posedge hclk) disable iff (!hresetn)
		ipl_n == ~LVL_NONE || ipl_n == ~LVL_BUS || ipl_n == ~LVL_TIMER)
		else $error("unused interrupt level driven");

	// Reset and stop travel together so the processor never sees half a halt
	chk_run_pair: assert property (@(posedge hclk) disable iff (!hresetn)
		proc_reset_n == proc_stop_n)
		else $error("reset and stop lines differ");

	// Both directions at once would fight on the module bus
	chk_xcvr_excl: assert property (@(posedge hclk) disable iff (!hresetn)
		!(!rx_en_n && !tx_en_n))
		else $error("transceiver enabled both ways");

	chk_req_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		!rts_n && s_q.cts2 && s_q.brst2 |=> !rts_n)
		else $error("request dropped before grant");

	chk_flash_off: assert property (@(posedge hclk) disable iff (!hresetn)
		!s_q.ctrl[CTRL_FLASH] |=> !s_q.flash)
		else $error("indicator flashing while not asked");

	chk_latch_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		!(s_q.ph_val && s_q.ph_wr && s_q.ph_addr == ADDR_CTRL) |=> $stable(s_q.ctrl))
		else $error("control latch changed without a write");

endmodule : mcg_glue

// ===== bench/mcg_far_model.sv
`timescale 1ns/1ps
module mcg_far_model #(
	parameter int GRANT_DLY = 6
) (
	input  wire logic hclk,
	input  wire logic rts_n,
	input  wire logic bus_cycle_ack_n,
	output logic      cpu_as_n,
	output logic      cts_n,
	output logic      module_bus_clock
);
	initial begin
		cpu_as_n = 1'b1;
		cts_n = 1'b1;
		module_bus_clock = 1'b0;
	end
	// Grant held while the request stands
	always begin
		@(posedge hclk iff rts_n === 1'b0);
		repeat (GRANT_DLY) @(posedge hclk);
		cts_n <= 1'b0;
		@(posedge hclk iff rts_n !== 1'b0);
		cts_n <= 1'b1;
	end
	// Bus clock stands low outside a grant; odd offset keeps it out of phase
	initial begin
		#37;
		forever begin
			#200;
			module_bus_clock = (cts_n === 1'b0) ? ~module_bus_clock : 1'b0;
		end
	end
	// Processor access: strobe held until acknowledged or 60 cycles pass, then released
	task automatic cpu_cycle(output int waited);
		waited = 0;
		cpu_as_n <= 1'b0;
		do begin
			@(posedge hclk);
			waited++;
		end while (bus_cycle_ack_n !== 1'b0 && waited < 60);
		cpu_as_n <= 1'b1;
		repeat (6) @(posedge hclk);
	endtask : cpu_cycle
endmodule : mcg_far_model

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
	import mcg_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, cpu_clk_en, proc_reset_n, proc_stop_n;
	logic        cpu_as_n, ack_n, timer_irq, bus_irq, rx_dir_n, rx_en_n, tx_dir_n, tx_en_n, rts_n, cts_n;
	logic        mbclk, bus_reset_n, gain_en, ytf_en, act_led, err_led, nv_wp_sw, nv_we_allow;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [2:0]  hsize, ipl_n, e;
	logic [1:0]  htrans;
	logic [7:0]  addr_sw;
	logic [3:0]  det_in, mem_sel;
	int          mismatches, check_count, n;

	mcg_glue #(.FLASH_CNT(4)) i_mcg_glue (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu_clk_en(cpu_clk_en),
		.proc_reset_n(proc_reset_n), .proc_stop_n(proc_stop_n), .cpu_as_n(cpu_as_n),
		.bus_cycle_ack_n(ack_n), .ipl_n(ipl_n), .timer_irq(timer_irq), .bus_irq(bus_irq),
		.addr_sw(addr_sw), .rx_dir_n(rx_dir_n), .rx_en_n(rx_en_n), .tx_dir_n(tx_dir_n),
		.tx_en_n(tx_en_n), .rts_n(rts_n), .cts_n(cts_n), .module_bus_clock(mbclk),
		.bus_reset_n(bus_reset_n), .gain_en(gain_en), .ytf_en(ytf_en), .act_led(act_led),
		.err_led(err_led), .det_in(det_in), .nv_wp_sw(nv_wp_sw), .nv_we_allow(nv_we_allow),
		.mem_sel(mem_sel));
	mcg_far_model i_mcg_far_model (.hclk(hclk), .rts_n(rts_n), .bus_cycle_ack_n(ack_n),
		.cpu_as_n(cpu_as_n), .cts_n(cts_n), .module_bus_clock(mbclk));

	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	////////////////////////////////////////////////////////////////
	task automatic cyc(input int k);
		repeat (k) @(posedge hclk);
	endtask : cyc
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Read data is taken at the edge that closes the data phase
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		hsize <= 3'b010;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task automatic cnt_en(input int k);
		n = 0;
		repeat (k) begin
			@(posedge hclk);
			n += int'(cpu_clk_en);
		end
	endtask : cnt_en
	task automatic tally_and_finish;
		$display("Checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////
	initial begin
		cyc(20000);
		mismatches++;
		tally_and_finish();
	end
	initial begin
		{hresetn, hsel, hwrite, timer_irq, bus_irq, nv_wp_sw} = 6'h00;
		{haddr, hwdata, htrans, hsize} = 69'h0;
		{addr_sw, det_in, bus_reset_n} = {8'hA5, 4'hB, 1'b1};
		mismatches = 0;
		check_count = 0;
		cyc(6);
		hresetn <= 1'b1;
		cyc(1);
		ahb(0, ADDR_CTRL, 0);
		chk("ctrl_reset", 32'(CTRL_RESET), rd);
		chk("reset_outs", 32'h3FF, 32'({proc_reset_n, proc_stop_n, ipl_n, rts_n, rx_dir_n, rx_en_n, tx_dir_n, tx_en_n}));
		cnt_en(20);
		chk("clk_div", 10, 32'(n));
		$display("Test reset done");
		ahb(1, ADDR_CTRL, 32'h40);
		cyc(2);
		cnt_en(20);
		chk("osc_off", 0, 32'(n));
		ahb(1, ADDR_CTRL, 32'h0F);
		cyc(2);
		chk("halted", 0, 32'({proc_reset_n, proc_stop_n}));
		chk("latch", 32'hF, 32'({err_led, act_led, ytf_en, gain_en}));
		ahb(1, ADDR_CTRL, 32'h70);
		cyc(2);
		n = 0;
		repeat (40) begin
			e[0] = err_led;
			@(posedge hclk);
			n += int'(e[0] !== err_led);
		end
		chk("flash", 1, 32'(n > 2));
		ahb(1, ADDR_CTRL, 32'h60);
		$display("Test control done");
		for (int i = 0; i < 4; i++) begin
			timer_irq <= i[1];
			bus_irq <= i[0];
			cyc(5);
			e = ~(i[1] ? LVL_TIMER : i[0] ? LVL_BUS : LVL_NONE);
			chk("ipl", 32'(e), 32'(ipl_n));
		end
		{timer_irq, bus_irq} <= 2'b00;
		cyc(5);
		repeat (2) begin
			i_mcg_far_model.cpu_cycle(n);
			chk("ack_time", 1, 32'(n <= 8));
			chk("ack_release", 1, 32'(ack_n));
		end
		bus_irq <= 1'b1;
		cyc(5);
		fork
			i_mcg_far_model.cpu_cycle(n);
			begin
				cyc(12);
				chk("ack_held", 1, 32'(ack_n));
				bus_irq <= 1'b0;
			end
		join
		chk("ack_late", 1, 32'(n > 12 && n < 60));
		$display("Test ack done");
		ahb(0, ADDR_ADDRSW, 0);
		chk("addr_sw", 32'hA5, rd);
		ahb(0, ADDR_STATUS, 0);
		chk("status", 32'h1B, rd & 32'h1F);
		chk("we_allow", 1, 32'(nv_we_allow));
		nv_wp_sw <= 1'b1;
		cyc(4);
		chk("we_block", 0, 32'(nv_we_allow));
		ahb(0, 8'h40, 0);
		chk("unmapped", 0, rd);
		ahb(1, ADDR_DECODE, 32'hA);
		cyc(2);
		chk("mem_sel", 32'hA, 32'(mem_sel));
		for (int i = 1; i < 3; i++) begin
			ahb(1, ADDR_XCVR, 32'(i));
			cyc(2);
			chk("xcvr", i == 1 ? 32'h3 : 32'hC, 32'({rx_dir_n, rx_en_n, tx_dir_n, tx_en_n}));
		end
		$display("Test status done");
		bus_reset_n <= 1'b0;
		cyc(4);
		chk("xcvr_reset", 32'hF, 32'({rx_dir_n, rx_en_n, tx_dir_n, tx_en_n}));
		ahb(1, ADDR_BUSREQ, 1);
		cyc(3);
		chk("req_blocked", 1, 32'(rts_n));
		bus_reset_n <= 1'b1;
		cyc(2);
		ahb(1, ADDR_BUSREQ, 1);
		cyc(3);
		chk("rts", 0, 32'(rts_n));
		n = 0;
		while (cts_n !== 1'b0 && n < 100) begin
			cyc(1);
			n++;
		end
		chk("rts_held", 0, 32'(rts_n));
		cyc(4);
		chk("rts_granted", 1, 32'(rts_n));
		$display("Test bus request done");
		tally_and_finish();
	end
endmodule : tb
